// ### sll_top.sv
// Serial latch loader: three-wire write port, three internal latches,
// power-down handling, reference divider and status multiplexer.
// Assumes the host stops serial_clk while latch_load_strobe is high.
`timescale 1ns/100ps

module sll_top
  import sll_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    serial_clk,
  input  wire logic                    serial_data_in,
  input  wire logic                    latch_load_strobe,
  input  wire logic                    chip_enable,
  input  wire logic                    pll_lock_in,
  output logic [REF_DIV_BITS-1:0]      ref_div,
  output logic [FB_DIV_BITS-1:0]       fb_div,
  output logic [PAYLOAD_BITS-1:0]      func_word,
  output logic                         counter_reset_pulse,
  output logic                         powered_down,
  output logic                         ref_tick,
  output logic                         word_loaded,
  output logic                         status_mux_output
);

  // ****************************************************************
  // Link domain shift register
  // ****************************************************************
  logic [WORD_BITS-1:0] shift_reg;

  always_ff @(posedge serial_clk)
  begin
    shift_reg <= {shift_reg[WORD_BITS-2:0], serial_data_in};
  end

  // ****************************************************************
  // Synchronisers into ref_clk
  // ****************************************************************
  logic [SYNC_STAGES-1:0] le_sync;
  logic [SYNC_STAGES-1:0] ce_sync;
  logic [SYNC_STAGES-1:0] lock_sync;
  logic                   le_prev;
  logic                   le_rise;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      le_sync   <= '0;
      ce_sync   <= '0;
      lock_sync <= '0;
      le_prev   <= 1'b0;
    end
    else
    begin
      le_sync   <= {le_sync[0], latch_load_strobe};
      ce_sync   <= {ce_sync[0], chip_enable};
      lock_sync <= {lock_sync[0], pll_lock_in};
      le_prev   <= le_sync[SYNC_STAGES-1];
    end
  end

  assign le_rise = le_sync[SYNC_STAGES-1] & ~le_prev;

  // Shift register is static while the strobe is high
  sll_word_s cap;
  assign cap = sll_word_s'(shift_reg);

  // ****************************************************************
  // Latches
  // ****************************************************************
  logic init_armed;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ref_div             <= REF_DIV_RST;
      fb_div              <= FB_DIV_RST;
      func_word           <= FUNC_RST;
      init_armed          <= 1'b0;
      counter_reset_pulse <= 1'b0;
      word_loaded         <= 1'b0;
    end
    else
    begin
      counter_reset_pulse <= 1'b0;
      word_loaded         <= le_rise;
      if (le_rise)
      begin
        case (cap.sel)
          SLL_SEL_REF:
          begin
            ref_div <= cap.payload[REF_DIV_LSB +: REF_DIV_BITS];
          end
          SLL_SEL_FB:
          begin
            fb_div <= cap.payload[FB_DIV_LSB +: FB_DIV_BITS];
            if (init_armed)
            begin
              counter_reset_pulse <= 1'b1;
              init_armed          <= 1'b0;
            end
          end
          SLL_SEL_FUNC:
          begin
            func_word <= cap.payload;
          end
          default:
          begin
            func_word           <= cap.payload;
            counter_reset_pulse <= 1'b1;
            init_armed          <= 1'b1;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Power-down
  // ****************************************************************
  // chip enable input
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      powered_down <= 1'b1;
    end
    else
    begin
      powered_down <= ~ce_sync[SYNC_STAGES-1]
                    | (func_word[PD_ASYNC_BIT] & ~func_word[PD_SYNC_BIT]);
    end
  end

  // ****************************************************************
  // Reference divider
  // ****************************************************************
  function automatic logic [REF_DIV_BITS-1:0] eff_div
  (
    input logic [REF_DIV_BITS-1:0] d
  );
    eff_div = (d == '0) ? REF_DIV_BITS'(1) : d;
  endfunction

  logic [REF_DIV_BITS-1:0] div_cnt;
  logic                    div_hold;
  assign div_hold = powered_down | counter_reset_pulse
                  | func_word[CNT_RST_BIT];

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      div_cnt  <= '0;
      ref_tick <= 1'b0;
    end
    else if (div_hold)
    begin
      div_cnt  <= '0;
      ref_tick <= 1'b0;
    end
    else if (div_cnt >= eff_div(ref_div) - REF_DIV_BITS'(1))
    begin
      div_cnt  <= '0;
      ref_tick <= 1'b1;
    end
    else
    begin
      div_cnt  <= div_cnt + REF_DIV_BITS'(1);
      ref_tick <= 1'b0;
    end
  end

  // ****************************************************************
  // Status multiplexer
  // ****************************************************************
  // lock detect on mux
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      status_mux_output <= 1'b0;
    end
    else
    begin
      case (func_word[MUX_LSB +: 3])
        MUX_LOCK:     status_mux_output <= lock_sync[SYNC_STAGES-1];
        MUX_REF_TICK: status_mux_output <= ref_tick;
        MUX_HIGH:     status_mux_output <= 1'b1;
        default:      status_mux_output <= 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_shift_msb_first: assert property (
    @(posedge serial_clk) disable iff (1'b0)
    ##1 shift_reg[0] == $past(serial_data_in))
    else $error("shift register missed a bit");

  a_ref_load: assert property (
    le_rise && cap.sel == SLL_SEL_REF
    |=> ref_div == $past(cap.payload[REF_DIV_LSB +: REF_DIV_BITS]))
    else $error("reference latch not loaded");

  a_fb_load: assert property (
    le_rise && cap.sel == SLL_SEL_FB
    |=> fb_div == $past(cap.payload[FB_DIV_LSB +: FB_DIV_BITS])
        && ref_div == $past(ref_div))
    else $error("feedback latch load wrong");

  a_func_load: assert property (
    le_rise && cap.sel[1]
    |=> func_word == $past(cap.payload) && fb_div == $past(fb_div))
    else $error("function latch load wrong");

  a_init_pulse: assert property (
    le_rise && cap.sel == SLL_SEL_INIT
    |=> counter_reset_pulse ##1 !counter_reset_pulse)
    else $error("init load gave no single reset pulse");

  a_pd_pin_fast: assert property (
    $fell(chip_enable) ##1 !chip_enable[*3] |-> powered_down)
    else $error("chip enable low did not power down");

  a_pd_keeps_load: assert property (
    powered_down && le_rise |=> word_loaded)
    else $error("load lost during power-down");

  a_div_one: assert property (
    (eff_div(ref_div) == REF_DIV_BITS'(1) && !div_hold)[*2]
    |=> ref_tick)
    else $error("divide by one gave no tick");

  c_init_load: cover property (le_rise && cap.sel == SLL_SEL_INIT);
  c_fb_after_init: cover property (
    le_rise && cap.sel == SLL_SEL_FB && init_armed);
  c_load_while_down: cover property (powered_down && le_rise);
  c_tick_div_one: cover property (
    ref_tick && ref_div == REF_DIV_BITS'(1));

endmodule

// ### sll_pkg.sv
// Constants, field layout and types of the serial latch loader.
// Assumes a 10 MHz system clock and a host-driven serial shift clock.
package sll_pkg;

  // ****************************************************************
  // Timing and widths
  // ****************************************************************
  localparam int WORD_BITS    = 24;
  localparam int SYNC_STAGES  = 2;
  localparam int SCLK_MAX_HZ  = 20_000_000;
  localparam int REF_CLK_HZ   = 10_000_000;
  localparam int REF_DIV_BITS = 14;
  localparam int FB_DIV_BITS  = 13;
  localparam int PAYLOAD_BITS = 22;

  // ****************************************************************
  // Field positions inside the 22-bit payload
  // ****************************************************************
  localparam int REF_DIV_LSB  = 0;
  localparam int FB_DIV_LSB   = 6;
  localparam int CNT_RST_BIT  = 0;
  localparam int PD_ASYNC_BIT = 1;
  localparam int MUX_LSB      = 2;
  localparam int PD_SYNC_BIT  = 19;

  // ****************************************************************
  // Reset values and status mux codes
  // ****************************************************************
  localparam logic [REF_DIV_BITS-1:0] REF_DIV_RST = 14'h0001;
  localparam logic [FB_DIV_BITS-1:0]  FB_DIV_RST  = 13'h0001;
  localparam logic [PAYLOAD_BITS-1:0] FUNC_RST    = 22'h000000;
  localparam logic [2:0] MUX_LOW      = 3'h0;
  localparam logic [2:0] MUX_LOCK     = 3'h1;
  localparam logic [2:0] MUX_REF_TICK = 3'h2;
  localparam logic [2:0] MUX_HIGH     = 3'h7;

  typedef enum logic [1:0]
  {
    SLL_SEL_REF  = 2'b00,
    SLL_SEL_FB   = 2'b01,
    SLL_SEL_FUNC = 2'b10,
    SLL_SEL_INIT = 2'b11
  } sll_sel_e;

  typedef struct packed
  {
    logic [PAYLOAD_BITS-1:0] payload;
    sll_sel_e                sel;
  } sll_word_s;

endpackage

// ### sll_host.sv
// Host model: serial master of the latch loader.
// Assumes a 10 MHz ref_clk; the link clock runs only within frames.
`timescale 1ns/100ps
module sll_host
(
  input  wire logic ref_clk,
  output logic      serial_clk,
  output logic      serial_data_in,
  output logic      latch_load_strobe
);
  initial
  begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    latch_load_strobe = 1'b0;
  end

  task automatic send_word(input logic [23:0] w);
    int i;
    @(posedge ref_clk);
    #1 latch_load_strobe = 1'b0;
    #13;
    for (i = 23; i >= 0; i--)
    begin
      serial_data_in = w[i];
      #32 serial_clk = 1'b1;
      #32 serial_clk = 1'b0;
    end
    serial_data_in = ~w[0];
    repeat (2) @(posedge ref_clk);
    #1 latch_load_strobe = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 latch_load_strobe = 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// ### test_serial_latch_loader.sv
// Self-checking bench of the latch loader with a host model.
// Assumes sll_pkg, sll_top and sll_host are compiled first.
`timescale 1ns/100ps
module test_serial_latch_loader;
  import sll_pkg::*;
  logic                    ref_clk, rst, chip_enable, pll_lock_in;
  logic                    serial_clk, serial_data_in, latch_load_strobe;
  logic [REF_DIV_BITS-1:0] ref_div, er;
  logic [FB_DIV_BITS-1:0]  fb_div, eb;
  logic [PAYLOAD_BITS-1:0] func_word, ef, p;
  logic                    crp, powered_down, ref_tick, word_loaded, smo;
  logic [31:0]             seed;
  logic                    armed;
  int                      error_cnt, check_count, loads, n_loads;
  int                      pulses, n_pulses, ticks, k;
  sll_sel_e                tbl [4] = '{SLL_SEL_REF, SLL_SEL_FB,
                                       SLL_SEL_INIT, SLL_SEL_FB};
  logic [2:0]              mtbl [3] = '{MUX_LOW, MUX_HIGH, MUX_LOCK};

  sll_top i_sll_top (.ref_clk(ref_clk), .rst(rst), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .latch_load_strobe(latch_load_strobe),
    .chip_enable(chip_enable), .pll_lock_in(pll_lock_in), .ref_div(ref_div),
    .fb_div(fb_div), .func_word(func_word), .counter_reset_pulse(crp),
    .powered_down(powered_down), .ref_tick(ref_tick),
    .word_loaded(word_loaded), .status_mux_output(smo));
  sll_host i_sll_host (.ref_clk(ref_clk), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .latch_load_strobe(latch_load_strobe));

  always @(posedge ref_clk)
  begin
    if (word_loaded === 1'b1) loads++;
    if (crp === 1'b1) pulses++;
    if (ref_tick === 1'b1) ticks++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction

  function automatic int exp_ticks(input int div, input int n);
    return n / ((div == 0) ? 1 : div);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic load(input sll_sel_e s, input logic [PAYLOAD_BITS-1:0] d);
    i_sll_host.send_word({d, s});
    n_loads++;
    if (s == SLL_SEL_REF) er = d[REF_DIV_LSB +: REF_DIV_BITS];
    if (s == SLL_SEL_FB) eb = d[FB_DIV_LSB +: FB_DIV_BITS];
    if (s[1]) ef = d;
    if (s == SLL_SEL_INIT || (s == SLL_SEL_FB && armed)) n_pulses++;
    if (s == SLL_SEL_FB) armed = 1'b0;
    if (s == SLL_SEL_INIT) armed = 1'b1;
    chk(32'(ref_div), 32'(er), "ref");
    chk(32'(fb_div), 32'(eb), "fb");
    chk(32'(func_word), 32'(ef), "func");
    chk(32'(loads), 32'(n_loads), "loads");
    chk(32'(pulses), 32'(n_pulses), "pulses");
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial
  begin
    #500000;
    error_cnt++;
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    chip_enable = 1'b1;
    pll_lock_in = 1'b0;
    seed = 32'hbda1ac30;
    armed = 1'b0;
    er = REF_DIV_RST;
    eb = FB_DIV_RST;
    ef = FUNC_RST;
    repeat (8) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(32'(ref_div), 32'(er), "rst ref");
    chk(32'(func_word), 32'(ef), "rst func");
    chk(32'(powered_down), 32'h00000000, "rst pd");
    $display("reset test done");
    for (k = 0; k < 12; k++)
    begin
      seed = lfsr(seed);
      p = seed[21:0] & 22'h3ffffc;
      load(k < 4 ? tbl[k] : sll_sel_e'(seed[23:22]), p);
    end
    $display("load test done");
    @(posedge ref_clk);
    #1 chip_enable = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk(32'(powered_down), 32'h00000001, "ce low");
    load(SLL_SEL_REF, 22'h000005);
    @(posedge ref_clk);
    #1 chip_enable = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk(32'(powered_down), 32'h00000000, "ce high");
    load(SLL_SEL_FUNC, 22'(1) << PD_ASYNC_BIT);
    #1 chk(32'(powered_down), 32'h00000001, "pd bit");
    load(SLL_SEL_FUNC, (22'(1) << PD_ASYNC_BIT) | (22'(1) << PD_SYNC_BIT));
    #1 chk(32'(powered_down), 32'h00000000, "pd sync");
    $display("power test done");
    for (k = 1; k <= 3; k += 2)
    begin
      load(SLL_SEL_REF, 22'(k));
      load(SLL_SEL_FB, 22'(k) << FB_DIV_LSB);
      repeat (4) @(posedge ref_clk);
      #1 ticks = 0;
      repeat (60) @(posedge ref_clk);
      #1 chk(32'(ticks), 32'(exp_ticks(k, 60)), "ticks");
    end
    load(SLL_SEL_FUNC, 22'(1) << CNT_RST_BIT);
    #1 ticks = 0;
    repeat (20) @(posedge ref_clk);
    #1 chk(32'(ticks), 32'h00000000, "held");
    $display("divide test done");
    for (k = 0; k < 6; k++)
    begin
      seed = lfsr(seed);
      load(SLL_SEL_FUNC, 22'(mtbl[k/2]) << MUX_LSB);
      @(posedge ref_clk);
      #1 pll_lock_in = seed[0];
      repeat (5) @(posedge ref_clk);
      #1 chk(32'(smo), 32'((mtbl[k/2] == MUX_HIGH) |
                (mtbl[k/2] == MUX_LOCK && seed[0])), "mux");
    end
    load(SLL_SEL_REF, 22'h000001);
    load(SLL_SEL_FUNC, 22'(MUX_REF_TICK) << MUX_LSB);
    #1 chk(32'(smo), 32'h00000001, "mux tick");
    $display("mux test done");
    complete_run();
  end
endmodule
